/* hs_switch_pkg.sv */
// Package with register map, field layout and timing constants of the switch control block.
package hs_switch_pkg;

  // Clock and timing base.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;

  // Cyclic timer on-times in microseconds.
  localparam int ON_T1_US = 100;
  localparam int ON_T2_US = 300;
  localparam int ON_T3_US = 1000;
  localparam int ON_T4_US = 10000;
  localparam int ON_T5_US = 20000;

  // Cyclic timer periods in milliseconds.
  localparam int PER_0_MS = 10;
  localparam int PER_1_MS = 20;
  localparam int PER_2_MS = 50;
  localparam int PER_3_MS = 100;
  localparam int PER_4_MS = 200;
  localparam int PER_5_MS = 1000;
  localparam int PER_6_MS = 2000;

  // Duty generator periods in nanoseconds, step count, and step length in clock cycles.
  localparam int PWM_STEPS = 255;
  localparam int PWM_200_NS = 5000000;
  localparam int PWM_400_NS = 2500000;
  localparam int PWM_STEP_200_DEF = PWM_200_NS / (PWM_STEPS * CLK_PERIOD_NS);
  localparam int PWM_STEP_400_DEF = PWM_400_NS / (PWM_STEPS * CLK_PERIOD_NS);

  // Register addresses.
  localparam logic [6:0] ADDR_CYC_A = 7'h0C;
  localparam logic [6:0] ADDR_CYC_B = 7'h0D;
  localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
  localparam logic [6:0] ADDR_SRC_A = 7'h14;
  localparam logic [6:0] ADDR_SRC_B = 7'h15;
  localparam logic [6:0] ADDR_DUTY_A = 7'h18;
  localparam logic [6:0] ADDR_DUTY_B = 7'h19;
  localparam logic [6:0] ADDR_FREQ = 7'h1C;

  // Writable bit masks and reset value.
  localparam logic [7:0] CYC_MASK = 8'h77;
  localparam logic [7:0] SD_MASK = 8'h70;
  localparam logic [7:0] SRC_MASK = 8'h77;
  localparam logic [7:0] FREQ_MASK = 8'h05;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions.
  localparam int ON_LSB = 4;
  localparam int OV_DIS_BIT = 6;
  localparam int UV_DIS_BIT = 5;
  localparam int REC_BIT = 4;
  localparam int FREQ_A_BIT = 0;
  localparam int FREQ_B_BIT = 2;
  localparam int SRC_FIELD_STRIDE = 4;

  // On-time codes that stop a timer.
  localparam logic [2:0] ON_LOW = 3'h0;
  localparam logic [2:0] ON_HIGH = 3'h6;
  localparam logic [2:0] ON_RSVD = 3'h7;

  // Switch source codes.
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON = 3'h1;
  localparam logic [2:0] SRC_CYC_A = 3'h2;
  localparam logic [2:0] SRC_CYC_B = 3'h3;
  localparam logic [2:0] SRC_GEN_A = 3'h4;
  localparam logic [2:0] SRC_GEN_B = 3'h5;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0][7:0] cyc_ctrl;
    logic [7:0] sd_ctrl;
    logic [1:0][7:0] src_ctrl;
    logic [1:0][7:0] duty;
    logic [7:0] freq;
    logic [11:0] tick_cnt;
    logic [1:0][14:0] cyc_cnt;
    logic [1:0][8:0] pre_cnt;
    logic [1:0][7:0] pwm_cnt;
    logic [1:0] cyc_out;
    logic [1:0] pwm_out;
    logic [3:0] sw_out;
    logic shut;
    logic [7:0] rd_data;
  } state_t;

  // On-time code to length in ticks.
  function automatic logic [14:0] on_ticks(input logic [2:0] code);
    case (code)
      3'h1: on_ticks = 15'(ON_T1_US * 1000 / TICK_NS);
      3'h2: on_ticks = 15'(ON_T2_US * 1000 / TICK_NS);
      3'h3: on_ticks = 15'(ON_T3_US * 1000 / TICK_NS);
      3'h4: on_ticks = 15'(ON_T4_US * 1000 / TICK_NS);
      3'h5: on_ticks = 15'(ON_T5_US * 1000 / TICK_NS);
      default: on_ticks = 15'h0000;
    endcase
  endfunction : on_ticks

  // Period code to length in ticks; the reserved code behaves as the longest period.
  function automatic logic [14:0] per_ticks(input logic [2:0] code);
    case (code)
      3'h0: per_ticks = 15'(PER_0_MS * 1000000 / TICK_NS);
      3'h1: per_ticks = 15'(PER_1_MS * 1000000 / TICK_NS);
      3'h2: per_ticks = 15'(PER_2_MS * 1000000 / TICK_NS);
      3'h3: per_ticks = 15'(PER_3_MS * 1000000 / TICK_NS);
      3'h4: per_ticks = 15'(PER_4_MS * 1000000 / TICK_NS);
      3'h5: per_ticks = 15'(PER_5_MS * 1000000 / TICK_NS);
      default: per_ticks = 15'(PER_6_MS * 1000000 / TICK_NS);
    endcase
  endfunction : per_ticks

endpackage : hs_switch_pkg

/* high_side_switch_timer_control.sv */
// Cyclic timers, duty generators, supply shutdown and source selection for four switches.
`timescale 1ns/1ns
`default_nettype none

// How the block is organised.
// Eight byte registers sit behind a write strobe and a read address.
// A write is taken at the rising edge at which the strobe is high.
// The read data shows the register at the read address one clock later.
// Bits that carry no field are never stored, so they always read as zero.
// Addresses 0x0C and 0x0D hold the two cyclic timers.
// Each timer register has its on-time code in bits 6:4 and its period code in 2:0.
// Address 0x10 holds the shutdown options in bits 6:4.
// Addresses 0x14 and 0x15 hold the switch source fields, two to a register.
// Addresses 0x18 and 0x19 hold the duty values of the two duty generators.
// Address 0x1C holds one frequency bit for each duty generator.

// Timing of the cyclic timers.
// One prescaler divides the clock down to a 0.1 ms tick that both timers share.
// Each timer counts ticks from zero up to its period and then wraps.
// Its output is high while the count is below the on-time and low for the rest.
// Two on-time codes stop the count and park the output low or high instead.
// The reserved on-time code parks the output low, like the halt-low code.
// The reserved period code runs as the longest period, so the timer never hangs.
// A write to a timer register clears its count and restarts the shared tick.
// The timer therefore starts at once, with no separate start command.
// The first on-time after a write to a timer parked low is one clock shorter than the later ones.

// Timing of the duty generators.
// A step prescaler divides the clock into steps, 255 steps to one period.
// The frequency bit halves the step length and so doubles the frequency.
// The output is high while the step count is below the duty value.
// Duty zero therefore never drives the output and duty 255 always does.

// Supply and load faults.
// A supply fault counts only while its shutdown option is left enabled.
// While a counted fault stands, all four switches are forced off.
// With recovery enabled the source fields are kept and the switches return.
// Without recovery the source fields are cleared, so the switches stay off.
// An overcurrent or overtemperature report clears only that switch's field.
// A restart clear wipes both source registers at once.
// It also wipes each timer register whose sensing input is high at that time.
// Hardware clears are applied after software writes, so a clear always wins.

// Latency of the outputs.
// The switch outputs, timer outputs and generator outputs are all registered.
// A timer or generator output reaches a switch one clock after it changes.
// A new source field reaches its switch one clock after the write is stored.
// A supply fault forces the switches off one clock after it is seen.
// A load fault clears the field at once and turns the switch off one clock later.
// The supply shutdown flag follows the counted fault with one clock of delay.

// Limitations a user must know.
// Reserved source codes leave the switch off, but software should not write them.
// A write to either timer register shifts the tick phase of the other timer once.
// The fault inputs are taken as synchronous to the clock, with no filtering here.
// Every register, counter and output clears on the synchronous reset.

module high_side_switch_timer_control
  import hs_switch_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int PWM_STEP_200 = PWM_STEP_200_DEF,
  parameter int PWM_STEP_400 = PWM_STEP_400_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register port.
  input wire logic reg_wr_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Supply and load conditions.
  input wire logic supply_overvolt,
  input wire logic supply_undervolt,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] overtemp,
  input wire logic restart_clear,
  input wire logic cyclic_sense_a,
  input wire logic cyclic_sense_b,
  // Switch and generator outputs.
  output logic [3:0] all_switch_outputs,
  output logic cyclic_timer_a_out,
  output logic cyclic_timer_b_out,
  output logic duty_gen_a_out,
  output logic duty_gen_b_out,
  output logic supply_shutdown
);

  state_t st_reg;
  state_t st_next;

  logic tick;
  logic [1:0] cyc_wr;
  logic [1:0] sense_use;
  logic [1:0][14:0] cyc_cnt_nx;
  logic [1:0] cyc_out_nx;
  logic [1:0][8:0] pre_nx;
  logic [1:0][7:0] pwm_cnt_nx;
  logic [1:0] pwm_out_nx;
  logic [1:0] freq_sel;
  logic [3:0] sw_raw;
  logic fault;

  // Shared 0.1 ms time base for both cyclic timers.
  assign tick = (st_reg.tick_cnt == 12'(TICK_CYCLES - 1));

  // A write to a timer register restarts its count from the period start.
  assign cyc_wr[0] = reg_wr_en && (reg_addr == ADDR_CYC_A);
  assign cyc_wr[1] = reg_wr_en && (reg_addr == ADDR_CYC_B);
  assign sense_use = {cyclic_sense_b, cyclic_sense_a};
  assign freq_sel = {st_reg.freq[FREQ_B_BIT], st_reg.freq[FREQ_A_BIT]};

  // Supply fault that is allowed to shut the switches down.
  assign fault = (supply_overvolt && !st_reg.sd_ctrl[OV_DIS_BIT]) ||
    (supply_undervolt && !st_reg.sd_ctrl[UV_DIS_BIT]);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      logic [2:0] on_code;
      logic [2:0] per_code;
      logic running;
      logic [14:0] cnt_inc;
      logic [8:0] step;
      logic pre_wrap;

      // Both timers decode the same field layout.
      assign on_code = st_reg.cyc_ctrl[g][ON_LSB +: 3];
      assign per_code = st_reg.cyc_ctrl[g][2:0];
      assign running = (on_code != ON_LOW) && (on_code != ON_HIGH) && (on_code != ON_RSVD);
      assign cnt_inc = st_reg.cyc_cnt[g] + 15'h0001;

      // The timer runs as soon as a running on-time is held; a write restarts it.
      always_comb begin
        if (!running || cyc_wr[g]) begin
          cyc_cnt_nx[g] = 15'h0000;
        end else if (tick) begin
          cyc_cnt_nx[g] = (cnt_inc >= per_ticks(per_code)) ? 15'h0000 : cnt_inc;
        end else begin
          cyc_cnt_nx[g] = st_reg.cyc_cnt[g];
        end
      end

      // On at the start of each period, off for the rest of it.
      always_comb begin
        if (running) begin
          cyc_out_nx[g] = (cyc_cnt_nx[g] < on_ticks(on_code));
        end else begin
          cyc_out_nx[g] = (on_code == ON_HIGH);
        end
      end

      // Duty generator step prescaler, length set by the frequency bit.
      assign step = freq_sel[g] ? 9'(PWM_STEP_400) : 9'(PWM_STEP_200);
      assign pre_wrap = (st_reg.pre_cnt[g] + 9'h001 >= step);
      assign pre_nx[g] = pre_wrap ? 9'h000 : st_reg.pre_cnt[g] + 9'h001;

      // Step counter runs 0..254; duty 255 is always above it, duty 0 never.
      always_comb begin
        if (!pre_wrap) begin
          pwm_cnt_nx[g] = st_reg.pwm_cnt[g];
        end else if (st_reg.pwm_cnt[g] == 8'(PWM_STEPS - 1)) begin
          pwm_cnt_nx[g] = 8'h00;
        end else begin
          pwm_cnt_nx[g] = st_reg.pwm_cnt[g] + 8'h01;
        end
      end
      assign pwm_out_nx[g] = (pwm_cnt_nx[g] < st_reg.duty[g]);
    end

    for (g = 0; g < 4; g++) begin : gen_switch
      logic [2:0] src;

      // Switch one and three sit low in their register, two and four high.
      assign src = st_reg.src_ctrl[g / 2][(g % 2) * SRC_FIELD_STRIDE +: 3];

      // Source selection for one switch.
      always_comb begin
        case (src)
          SRC_OFF: sw_raw[g] = 1'b0;
          SRC_ON: sw_raw[g] = 1'b1;
          SRC_CYC_A: sw_raw[g] = st_reg.cyc_out[0];
          SRC_CYC_B: sw_raw[g] = st_reg.cyc_out[1];
          SRC_GEN_A: sw_raw[g] = st_reg.pwm_out[0];
          SRC_GEN_B: sw_raw[g] = st_reg.pwm_out[1];
          default: sw_raw[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Next state: register writes, hardware clears, counters and outputs.
  always_comb begin
    st_next = st_reg;

    // Software writes; reserved bits are never stored.
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_CYC_A: st_next.cyc_ctrl[0] = reg_wr_data & CYC_MASK;
        ADDR_CYC_B: st_next.cyc_ctrl[1] = reg_wr_data & CYC_MASK;
        ADDR_SHUTDOWN: st_next.sd_ctrl = reg_wr_data & SD_MASK;
        ADDR_SRC_A: st_next.src_ctrl[0] = reg_wr_data & SRC_MASK;
        ADDR_SRC_B: st_next.src_ctrl[1] = reg_wr_data & SRC_MASK;
        ADDR_DUTY_A: st_next.duty[0] = reg_wr_data;
        ADDR_DUTY_B: st_next.duty[1] = reg_wr_data;
        ADDR_FREQ: st_next.freq = reg_wr_data & FREQ_MASK;
        default: st_next.freq = st_reg.freq;
      endcase
    end

    // Hardware clears come after the write so a same-cycle event wins.
    for (int i = 0; i < 4; i++) begin
      if (overcurrent[i] || overtemp[i]) begin
        st_next.src_ctrl[i / 2][(i % 2) * SRC_FIELD_STRIDE +: 3] = SRC_OFF;
      end
    end

    // Restart clear of the switches also clears timers used for sensing.
    if (restart_clear) begin
      st_next.src_ctrl = '0;
      for (int t = 0; t < 2; t++) begin
        if (sense_use[t]) begin
          st_next.cyc_ctrl[t] = REG_RESET;
        end
      end
    end

    // Without recovery a supply shutdown leaves the switches off for good.
    if (fault && !st_reg.sd_ctrl[REC_BIT]) begin
      st_next.src_ctrl = '0;
    end

    // Time base and channel counters. A timer write also restarts the time base, so the
    // first on-time after the write cannot be lost to a tick that falls in the cycle
    // right after the write. The other timer then sees one stretched tick.
    st_next.tick_cnt = (tick || (|cyc_wr)) ? 12'h000 : st_reg.tick_cnt + 12'h001;
    st_next.cyc_cnt = cyc_cnt_nx;
    st_next.cyc_out = cyc_out_nx;
    st_next.pre_cnt = pre_nx;
    st_next.pwm_cnt = pwm_cnt_nx;
    st_next.pwm_out = pwm_out_nx;

    // With recovery the outputs return to their settings once the fault clears.
    st_next.shut = fault;
    st_next.sw_out = fault ? 4'h0 : sw_raw;

    // Read data, one cycle after the address.
    case (reg_addr)
      ADDR_CYC_A: st_next.rd_data = st_reg.cyc_ctrl[0] & CYC_MASK;
      ADDR_CYC_B: st_next.rd_data = st_reg.cyc_ctrl[1] & CYC_MASK;
      ADDR_SHUTDOWN: st_next.rd_data = st_reg.sd_ctrl & SD_MASK;
      ADDR_SRC_A: st_next.rd_data = st_reg.src_ctrl[0] & SRC_MASK;
      ADDR_SRC_B: st_next.rd_data = st_reg.src_ctrl[1] & SRC_MASK;
      ADDR_DUTY_A: st_next.rd_data = st_reg.duty[0];
      ADDR_DUTY_B: st_next.rd_data = st_reg.duty[1];
      ADDR_FREQ: st_next.rd_data = st_reg.freq & FREQ_MASK;
      default: st_next.rd_data = 8'h00;
    endcase
  end

  // State register; every field clears on reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rd_data = st_reg.rd_data;
  assign all_switch_outputs = st_reg.sw_out;
  assign cyclic_timer_a_out = st_reg.cyc_out[0];
  assign cyclic_timer_b_out = st_reg.cyc_out[1];
  assign duty_gen_a_out = st_reg.pwm_out[0];
  assign duty_gen_b_out = st_reg.pwm_out[1];
  assign supply_shutdown = st_reg.shut;

endmodule : high_side_switch_timer_control

`default_nettype wire

/* hs_load_model.sv */
// Model of the four switched loads, reporting overcurrent and overtemperature.
`timescale 1ns/1ns
`default_nettype none
module hs_load_model (
  // Clock.
  input wire logic clk,
  // Switch drive and fault commands from the bench.
  input wire logic [3:0] switch_on,
  input wire logic [3:0] short_cmd,
  input wire logic [3:0] hot_cmd,
  // Fault reports.
  output logic [3:0] overcurrent,
  output logic [3:0] overtemp
);
  // A faulty load reports only while it is driven, so a cleared switch drops its report.
  initial {overcurrent, overtemp} = 8'h00;
  always @(posedge clk) begin
    overcurrent <= switch_on & short_cmd;
    overtemp <= switch_on & hot_cmd;
  end
endmodule : hs_load_model
`default_nettype wire

/* high_side_switch_timer_control_assertions.sv */
// Port checker for the switch control block.
`timescale 1ns/1ns
`default_nettype none
module hs_switch_checker #(parameter int TICK_CYCLES = 2500) (
  // Clock, reset and register port.
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  // Conditions and outputs.
  input wire logic supply_overvolt,
  input wire logic supply_undervolt,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] overtemp,
  input wire logic restart_clear,
  input wire logic [3:0] all_switch_outputs,
  input wire logic cyclic_timer_b_out,
  input wire logic duty_gen_a_out,
  input wire logic supply_shutdown
);
  localparam int ON1_MAX = TICK_CYCLES + 4;
  logic [7:0] duty_a_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Mirror of the first duty value, taken from the write strobes.
  always_ff @(posedge clk) begin
    if (srst) duty_a_reg <= 8'h00;
    else if (reg_wr_en && reg_addr == 7'h18) duty_a_reg <= reg_wr_data;
  end
  // A write of one on-time code to the second timer.
  sequence s_wr_b(logic [2:0] code);
    reg_wr_en && !restart_clear && reg_addr == 7'h0D && reg_wr_data[6:4] == code;
  endsequence
  a_resv_bits_zero: assert property ($past(reg_addr) inside {7'h0D, 7'h10, 7'h14, 7'h15}
    |-> (reg_rd_data & (($past(reg_addr) == 7'h10) ? 8'h8F : 8'h88)) == 8'h00)
    else $error("reserved bit reads one");
  a_shut_all_off: assert property (supply_shutdown |-> all_switch_outputs == 4'h0)
    else $error("switch on during shutdown");
  a_fault_gone: assert property (!supply_overvolt && !supply_undervolt |=> !supply_shutdown)
    else $error("shutdown without supply fault");
  a_fault_clears: assert property ((overcurrent | overtemp) != 4'h0 |-> ##2
    (all_switch_outputs & $past(overcurrent | overtemp, 2)) == 4'h0)
    else $error("faulty switch still on");
  a_halt_low: assert property (s_wr_b(3'h0) |-> ##2 !cyclic_timer_b_out)
    else $error("halted timer not low");
  a_halt_high: assert property (s_wr_b(3'h6) |-> ##2 cyclic_timer_b_out)
    else $error("halted timer not high");
  a_run_start: assert property (s_wr_b(3'h1) |-> ##2 cyclic_timer_b_out)
    else $error("timer did not start");
  a_short_pulse: assert property (s_wr_b(3'h1) |-> ##[3:ON1_MAX] !cyclic_timer_b_out)
    else $error("short on-time too long");
  a_duty_full: assert property (duty_a_reg == 8'hFF && $past(duty_a_reg) == 8'hFF |-> duty_gen_a_out)
    else $error("full duty not high");
  a_duty_zero: assert property (duty_a_reg == 8'h00 && $past(duty_a_reg) == 8'h00 |-> !duty_gen_a_out)
    else $error("zero duty not low");
endmodule : hs_switch_checker
bind high_side_switch_timer_control hs_switch_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk,
  .srst, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data, .supply_overvolt, .supply_undervolt,
  .overcurrent, .overtemp, .restart_clear, .all_switch_outputs, .cyclic_timer_b_out,
  .duty_gen_a_out, .supply_shutdown);
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the switch control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import hs_switch_pkg::*;
;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic ov = 1'b0;
  logic uv = 1'b0;
  logic restart_clear = 1'b0;
  logic [1:0] sense = 2'b00;
  logic [3:0] short_cmd = 4'h0;
  logic [3:0] hot_cmd = 4'h0;
  logic [7:0] rdat;
  logic [3:0] oc, ot, sw;
  logic ta, tb_o, ga, gb, shut;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 32'he3a07417;
  int hi, per, on;
  logic [7:0] rnd;
  logic [6:0] addrs [5] = '{ADDR_CYC_B, ADDR_SHUTDOWN, ADDR_SRC_A, ADDR_SRC_B, 7'h1F};
  logic [7:0] masks [5] = '{CYC_MASK, SD_MASK, SRC_MASK, SRC_MASK, 8'h00};
  logic [7:0] sd_t [5] = '{8'h00, 8'h10, 8'h40, 8'h30, 8'h10};
  initial forever #20 clk = ~clk;
  high_side_switch_timer_control #(.TICK_CYCLES(TK), .PWM_STEP_200(4), .PWM_STEP_400(2))
    u_high_side_switch_timer_control (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(rdat), .supply_overvolt(ov),
    .supply_undervolt(uv), .overcurrent(oc), .overtemp(ot), .restart_clear(restart_clear),
    .cyclic_sense_a(sense[0]), .cyclic_sense_b(sense[1]), .all_switch_outputs(sw),
    .cyclic_timer_a_out(ta), .cyclic_timer_b_out(tb_o), .duty_gen_a_out(ga),
    .duty_gen_b_out(gb), .supply_shutdown(shut));
  hs_load_model u_hs_load_model (.clk(clk), .switch_on(sw), .short_cmd(short_cmd),
    .hot_cmd(hot_cmd), .overcurrent(oc), .overtemp(ot));
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Compares a value with its expectation.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // Register access on the falling edge; read data is taken one cycle after the address.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge clk);
    check(rdat, exp);
  endtask : rdc
  // Waits, with a bound, until switch one shows the given level; returns the cycles spent.
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (sw[0] !== v) begin
      @(negedge clk);
      n++;
      if (n > 25000) begin
        check(1'b0, 1'b1);
        finish_test();
      end
    end
  endtask : wait_lvl
  // Measures one whole pulse of switch one after skipping the first one.
  task automatic meas(output int h, output int p);
    int lo;
    wait_lvl(1'b1, lo);
    wait_lvl(1'b0, lo);
    wait_lvl(1'b1, lo);
    wait_lvl(1'b0, h);
    wait_lvl(1'b1, lo);
    p = h + lo;
  endtask : meas
  // Main sequence.
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    foreach (addrs[i]) rdc(addrs[i], 8'h00);
    repeat (3) foreach (addrs[i]) begin
      rnd = 8'($random(seed)) & 8'hDD;
      wr(addrs[i], rnd);
      rdc(addrs[i], rnd & masks[i]);
    end
    $display("test registers done");
    // Every source code on every switch, with fixed timer and generator levels.
    wr(ADDR_CYC_A, 8'h00);
    wr(ADDR_CYC_B, 8'h60);
    wr(ADDR_DUTY_A, 8'hFF);
    wr(ADDR_DUTY_B, 8'h00);
    wr(ADDR_SRC_B, 8'h00);
    check({ta, tb_o, ga, gb}, 4'h6);
    for (int s = 0; s < 4; s++) for (int c = 0; c < 6; c++) begin
      wr(s < 2 ? ADDR_SRC_A : ADDR_SRC_B, 8'(c << (4 * (s % 2))));
      @(negedge clk);
      check(sw, 4'(c == 1 || c == 3 || c == 4) << s);
    end
    $display("test sources done");
    // Duty generator at half duty for both frequency settings.
    wr(ADDR_SRC_A, 8'h04);
    wr(ADDR_DUTY_A, 8'h80);
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_FREQ, 8'(f));
      meas(hi, per);
      check(per, 255 * (4 >> f));
      check(hi, 128 * (4 >> f));
    end
    // Timer on-times and periods, timer assigned before its on-time is written.
    wr(ADDR_SRC_A, 8'h03);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CYC_B, 8'(((k + 1) << 4) | k));
      meas(hi, per);
      on = (k == 0 ? 1 : k == 1 ? 3 : 10) * TK;
      check(per, (k == 0 ? 100 : k == 1 ? 200 : 500) * TK);
      check(hi > on - TK && hi <= on + TK, 1'b1);
    end
    wr(ADDR_CYC_B, 8'h00);
    repeat (2) @(negedge clk);
    check(sw, 4'h0);
    $display("test timers done");
    // Supply faults against the shutdown and recovery options.
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_SHUTDOWN, sd_t[i]);
      wr(ADDR_SRC_A, 8'h01);
      {ov, uv} = {1'(5'b00111 >> i), 1'(5'b11000 >> i)};
      repeat (3) @(negedge clk);
      check({sw[0], shut}, 5'b01100 >> i & 1 ? 2'b10 : 2'b01);
      {ov, uv} = 2'b00;
      repeat (3) @(negedge clk);
      check(sw[0], 5'b11110 >> i & 1);
    end
    $display("test supply done");
    // Load faults clear only the affected source fields.
    wr(ADDR_SRC_A, 8'h11);
    wr(ADDR_SRC_B, 8'h11);
    {short_cmd, hot_cmd} = 8'h24;
    repeat (4) @(negedge clk);
    rdc(ADDR_SRC_A, 8'h01);
    rdc(ADDR_SRC_B, 8'h10);
    check(sw, 4'h9);
    {short_cmd, hot_cmd} = 8'h00;
    // Restart clear with the second timer used for sensing.
    wr(ADDR_CYC_A, 8'h60);
    wr(ADDR_CYC_B, 8'h10);
    sense = 2'b10;
    restart_clear = 1'b1;
    @(negedge clk);
    restart_clear = 1'b0;
    rdc(ADDR_CYC_B, 8'h00);
    rdc(ADDR_CYC_A, 8'h60);
    check(ta, 1'b1);
    rdc(ADDR_SRC_A, 8'h00);
    // A second reset in mid-run clears the registers again.
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rdc(ADDR_CYC_A, 8'h00);
    rdc(ADDR_SRC_B, 8'h00);
    $display("test faults done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
